// ==== bsp_pkg.sv ====
package bsp_pkg;
  localparam int BURST_LEN     = 4;
  localparam int LANE_W        = 9;
  localparam int DATA_W_WIDE   = 36;
  localparam int DATA_W_NARROW = 18;
  // address lines select a whole four-beat burst
  localparam int ADDR_W_WIDE   = 17;
  localparam int ADDR_W_NARROW = 18;
  localparam int LAT_DLL_ON    = 2;
  localparam int LAT_DLL_OFF   = 1;
  localparam int CLK_PERIOD_NS = 10;
  localparam int K_PERIOD_NS   = 40;
  localparam int K_DIV         = K_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CMD_FIFO_DEPTH = 16;
  localparam int WR_SLOTS      = 5;
  localparam int RD_PIPE_W     = 8;
  typedef enum logic [1:0] {RS_IDLE, RS_FIRST, RS_SECOND} bsp_rseq_t;
endpackage : bsp_pkg

// ==== bsp_link_if.sv ====
`timescale 1ns/10ps
interface bsp_link_if #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 17
);
  localparam int LANES = DATA_W / bsp_pkg::LANE_W;
  logic              k_clk;
  logic              k_clk_n;
  logic [ADDR_W-1:0] address_lines;
  logic              rd_sel_n;
  logic              wr_sel_n;
  logic [DATA_W-1:0] wr_data;
  logic [LANES-1:0]  byte_lane_mask_n;
  logic              dll_on;
  logic [DATA_W-1:0] rd_data;
  logic              echo_strobe;
  logic              echo_strobe_inverted;
  logic              output_valid_flag;

  modport mem (
    input  k_clk, k_clk_n, address_lines, rd_sel_n, wr_sel_n, wr_data,
    input  byte_lane_mask_n, dll_on,
    output rd_data, echo_strobe, echo_strobe_inverted, output_valid_flag
  );
  modport ctrl (
    output k_clk, k_clk_n, address_lines, rd_sel_n, wr_sel_n, wr_data,
    output byte_lane_mask_n, dll_on,
    input  rd_data, echo_strobe, echo_strobe_inverted, output_valid_flag
  );
endinterface : bsp_link_if

// ==== bsp_fifo.sv ====
`timescale 1ns/10ps
module bsp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1)
  begin : g_bad_param
    $error("fifo depth must be a power of two of at least 2");
  end

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW:0]  wp_ff;
  logic [AW:0]  rp_ff;
  wire          push = i_in_valid && o_in_ready;
  wire          pop  = o_out_valid && i_out_ready;

  assign o_in_ready  = (wp_ff - rp_ff) != (AW+1)'(DEPTH);
  assign o_out_valid = wp_ff != rp_ff;
  assign o_out_data  = mem_ff[rp_ff[AW-1:0]];

  always_ff @(posedge i_clk)
  begin
    if (push)
      mem_ff[wp_ff[AW-1:0]] <= i_in_data;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
    end
    else
    begin
      wp_ff <= wp_ff + (AW+1)'(push);
      rp_ff <= rp_ff + (AW+1)'(pop);
    end
  end
endmodule : bsp_fifo

// ==== bsp_mem.sv ====
// Summary of operation
// - 36-bit x 512K or 18-bit x 1M organisation
// - every command moves exactly four beats
// - read and write ports run concurrently
// - address and selects taken on rising clock
// - host alternates read and write address edges
// - write beats one, three on rising clock
// - write beats two, four on inverted clock
// - per-beat byte masks gate each lane
// - first write beat one cycle after command
// - write occupies two clock cycles
// - read beats one, three after 2.0 cycles
// - read beats two, four on inverted clock
// - read delivery occupies two clock cycles
// - complementary echo strobes accompany read data
// - valid flag marks read beats, strobe aligned
// - dll off gives latency of one cycle
// - address ignored when nothing selected
`timescale 1ns/10ps
module bsp_mem #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 17
) (
  bsp_link_if.mem   link,
  input  wire logic i_resetn,
  output logic      o_dll_bypass
);
  localparam int LW    = bsp_pkg::LANE_W;
  localparam int LANES = DATA_W / LW;
  localparam int NB    = bsp_pkg::BURST_LEN;
  localparam int AMAX  = (DATA_W == bsp_pkg::DATA_W_WIDE) ?
                         bsp_pkg::ADDR_W_WIDE : bsp_pkg::ADDR_W_NARROW;

  // narrower address only to keep simulation memory small
  if (!(DATA_W == bsp_pkg::DATA_W_WIDE || DATA_W == bsp_pkg::DATA_W_NARROW)
      || ADDR_W < 1 || ADDR_W > AMAX)
  begin : g_bad_param
    $error("unsupported data or address width");
  end

  function automatic logic [DATA_W-1:0] lane_merge(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [LANES-1:0]  mask_n
  );
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int l = 0; l < LANES; l++)
      if (!mask_n[l])
        res[l*LW +: LW] = new_w[l*LW +: LW];
    return res;
  endfunction : lane_merge

  // dll control arrives unrelated to k, two flops first
  logic              dll_s1_ff;
  logic              dll_s2_ff;
  logic              rv1_ff;
  logic              rv2_ff;
  logic [ADDR_W-1:0] ra1_ff;
  logic [ADDR_W-1:0] ra2_ff;
  logic              wv1_ff;
  logic              wv2_ff;
  logic              wv3_ff;
  logic [ADDR_W-1:0] wa1_ff;
  logic [ADDR_W-1:0] wa2_ff;
  logic [ADDR_W-1:0] wa3_ff;
  logic [DATA_W-1:0] fd_ff;
  logic [LANES-1:0]  fbw_ff;
  logic [DATA_W-1:0] rbuf_ff [NB];
  bsp_pkg::bsp_rseq_t rs_ff;
  bsp_pkg::bsp_rseq_t nxt_rs;
  logic [DATA_W-1:0] q_rise_ff;
  logic [DATA_W-1:0] q_fall_ff;
  logic              qvr_ff;
  logic              qvf_ff;

  // read wins a same-edge collision; the write is dropped
  wire rd_req = !link.rd_sel_n && !rv1_ff;
  wire wr_req = !link.wr_sel_n && !wv1_ff && !rd_req;
  wire lat1   = !dll_s2_ff;

  wire              fetch_v = lat1 ? rv1_ff : rv2_ff;
  wire [ADDR_W-1:0] fetch_a = lat1 ? ra1_ff : ra2_ff;

  logic              bwe [NB];
  logic [ADDR_W-1:0] bwa [NB];
  logic [DATA_W-1:0] bwd [NB];
  logic [LANES-1:0]  bwm [NB];
  logic [DATA_W-1:0] rd_word [NB];

  always_ff @(posedge link.k_clk)
  begin
    dll_s1_ff <= link.dll_on;
    dll_s2_ff <= dll_s1_ff;
  end

  // command capture: rising k only
  always_ff @(posedge link.k_clk)
  begin
    if (!i_resetn)
    begin
      rv1_ff <= 1'b0;
      rv2_ff <= 1'b0;
      wv1_ff <= 1'b0;
      wv2_ff <= 1'b0;
      wv3_ff <= 1'b0;
    end
    else
    begin
      rv1_ff <= rd_req;
      rv2_ff <= rv1_ff;
      wv1_ff <= wr_req;
      wv2_ff <= wv1_ff;
      wv3_ff <= wv2_ff;
    end
  end

  always_ff @(posedge link.k_clk)
  begin
    if (rd_req)
      ra1_ff <= link.address_lines;
    if (wr_req)
      wa1_ff <= link.address_lines;
    ra2_ff <= ra1_ff;
    wa2_ff <= wa1_ff;
    wa3_ff <= wa2_ff;
  end

  // beats two and four with their masks on the inverted clock
  always_ff @(posedge link.k_clk_n)
  begin
    fd_ff  <= link.wr_data;
    fbw_ff <= link.byte_lane_mask_n;
  end

  // beat 0 one cycle after the command, late write buffer after
  for (genvar b = 0; b < NB; b++)
  begin : g_beat
    logic [DATA_W-1:0] mem_ff [2**ADDR_W];
    wire               rise = (b % 2) == 0;

    assign bwe[b] = (b == 0) ? wv1_ff : (b == NB-1) ? wv3_ff : wv2_ff;
    assign bwa[b] = (b == 0) ? wa1_ff : (b == NB-1) ? wa3_ff : wa2_ff;
    assign bwd[b] = rise ? link.wr_data : fd_ff;
    assign bwm[b] = rise ? link.byte_lane_mask_n : fbw_ff;
    // forward bytes landing this very edge; a beat 0 landing now
    // belongs to a write issued after the read, which must not show
    assign rd_word[b] = (b != 0 && bwe[b] && bwa[b] == fetch_a) ?
                        lane_merge(mem_ff[fetch_a], bwd[b], bwm[b]) :
                        mem_ff[fetch_a];

    always_ff @(posedge link.k_clk)
    begin
      if (bwe[b])
        mem_ff[bwa[b]] <= lane_merge(mem_ff[bwa[b]], bwd[b], bwm[b]);
    end

    always_ff @(posedge link.k_clk)
    begin
      if (!i_resetn)
        rbuf_ff[b] <= '0;
      else if (fetch_v)
        rbuf_ff[b] <= rd_word[b];
    end
  end

  always_comb
  begin
    case (rs_ff)
      bsp_pkg::RS_IDLE:   nxt_rs = bsp_pkg::RS_IDLE;
      bsp_pkg::RS_FIRST:  nxt_rs = bsp_pkg::RS_SECOND;
      bsp_pkg::RS_SECOND: nxt_rs = bsp_pkg::RS_IDLE;
      default:            nxt_rs = bsp_pkg::RS_IDLE;
    endcase
    if (fetch_v)
      nxt_rs = bsp_pkg::RS_FIRST;
  end

  // read sequencing on rising k
  always_ff @(posedge link.k_clk)
  begin
    if (!i_resetn)
    begin
      rs_ff     <= bsp_pkg::RS_IDLE;
      q_rise_ff <= '0;
      qvr_ff    <= 1'b0;
    end
    else
    begin
      rs_ff <= nxt_rs;
      if (fetch_v)
        q_rise_ff <= rd_word[0];
      else if (rs_ff == bsp_pkg::RS_FIRST)
        q_rise_ff <= rbuf_ff[2];
      qvr_ff <= fetch_v || rs_ff == bsp_pkg::RS_FIRST;
    end
  end

  // half-cycle path from the rising-k flops, same clock source
  always_ff @(posedge link.k_clk_n)
  begin
    if (!i_resetn)
    begin
      q_fall_ff <= '0;
      qvf_ff    <= 1'b0;
    end
    else
    begin
      if (rs_ff == bsp_pkg::RS_FIRST)
        q_fall_ff <= rbuf_ff[1];
      else if (rs_ff == bsp_pkg::RS_SECOND)
        q_fall_ff <= rbuf_ff[3];
      qvf_ff <= rs_ff != bsp_pkg::RS_IDLE;
    end
  end

  always_ff @(posedge link.k_clk)
  begin
    if (!i_resetn)
      o_dll_bypass <= 1'b1;
    else
      o_dll_bypass <= lat1;
  end

  // ddr output: each half of k shows the flop of its own edge
  assign link.rd_data           = link.k_clk ? q_rise_ff : q_fall_ff;
  assign link.output_valid_flag = link.k_clk ? qvr_ff : qvf_ff;
  // echoes follow k itself so edges track the data mux
  assign link.echo_strobe          = link.k_clk;
  assign link.echo_strobe_inverted = link.k_clk_n;
endmodule : bsp_mem

// ==== bsp_host.sv ====
`timescale 1ns/10ps
module bsp_host #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 17
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_resetn,
  input  wire logic                    i_dll_on,
  input  wire logic                    i_cmd_valid,
  output logic                         o_cmd_ready,
  input  wire logic                    i_cmd_wr,
  input  wire logic [ADDR_W-1:0]       i_cmd_addr,
  input  wire logic [4*DATA_W-1:0]     i_cmd_data,
  input  wire logic [4*DATA_W/9-1:0]   i_cmd_mask_n,
  output logic                         o_rd_valid,
  output logic [4*DATA_W-1:0]          o_rd_data,
  bsp_link_if.ctrl                     link
);
  localparam int LANES = DATA_W / bsp_pkg::LANE_W;
  localparam int NB    = bsp_pkg::BURST_LEN;
  localparam int NS    = bsp_pkg::WR_SLOTS;
  localparam int CW    = 1 + ADDR_W + NB*LANES + NB*DATA_W;

  if (bsp_pkg::K_DIV != 4 || DATA_W % bsp_pkg::LANE_W != 0)
  begin : g_bad_param
    $error("host phases need k at a quarter of i_clk");
  end

  logic              f_valid;
  logic              pop;
  logic [CW-1:0]     f_data;
  logic [1:0]        ph_ff;
  logic              rslot_ff;
  logic              k_ff;
  logic              kn_ff;
  logic              rd_n_ff;
  logic              wr_n_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] d_ff;
  logic [LANES-1:0]  bw_ff;
  logic              dll_ff;
  logic [DATA_W-1:0] wsd_ff [NS];
  logic [LANES-1:0]  wsm_ff [NS];
  logic [DATA_W-1:0] nxt_wsd [NS];
  logic [LANES-1:0]  nxt_wsm [NS];
  logic [bsp_pkg::RD_PIPE_W-1:0] rpipe_ff;
  logic [DATA_W-1:0] rbuf_ff [NB-1];

  bsp_fifo #(.W(CW), .DEPTH(bsp_pkg::CMD_FIFO_DEPTH)) u_cmd_fifo (
    .i_clk       (i_clk),
    .i_resetn    (i_resetn),
    .i_in_valid  (i_cmd_valid),
    .o_in_ready  (o_cmd_ready),
    .i_in_data   ({i_cmd_wr, i_cmd_addr, i_cmd_mask_n, i_cmd_data}),
    .o_out_valid (f_valid),
    .i_out_ready (pop),
    .o_out_data  (f_data)
  );

  wire [1:0]        nxt_ph   = ph_ff + 2'h1;
  wire              opp      = !ph_ff[0];
  wire              cmd_slot = ph_ff == 2'h2;
  wire              f_wr     = f_data[CW-1];
  wire [ADDR_W-1:0] f_addr   = f_data[CW-2 -: ADDR_W];
  // strict alternation; a head of the wrong kind waits a slot
  assign pop = cmd_slot && f_valid && (f_wr != rslot_ff);
  wire              wload    = pop && f_wr;
  wire              rissue   = pop && !f_wr;
  wire [2:0]        rfirst   = dll_ff ? 3'h4 : 3'h2;

  // slot 0 drives now; a write fills slots 1..4, skipping one half
  for (genvar i = 0; i < NS; i++)
  begin : g_slot
    if (i == 0)
    begin : g_head
      assign nxt_wsd[i] = wsd_ff[1];
      assign nxt_wsm[i] = wsm_ff[1];
    end
    else
    begin : g_body
      assign nxt_wsd[i] = wload ? f_data[(i-1)*DATA_W +: DATA_W] :
                          (i < NS-1) ? wsd_ff[(i+1)%NS] : '0;
      assign nxt_wsm[i] = wload ? f_data[NB*DATA_W + (i-1)*LANES +: LANES] :
                          (i < NS-1) ? wsm_ff[(i+1)%NS] : '1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      ph_ff    <= 2'h0;
      k_ff     <= 1'b1;
      kn_ff    <= 1'b0;
      rslot_ff <= 1'b1;
      rd_n_ff  <= 1'b1;
      wr_n_ff  <= 1'b1;
      addr_ff  <= '0;
      dll_ff   <= 1'b0;
      d_ff     <= '0;
      bw_ff    <= '1;
      rpipe_ff <= '0;
      o_rd_valid <= 1'b0;
      for (int i = 0; i < NS; i++)
      begin
        wsd_ff[i] <= '0;
        wsm_ff[i] <= '1;
      end
    end
    else
    begin
      ph_ff  <= nxt_ph;
      k_ff   <= !nxt_ph[1];
      kn_ff  <= nxt_ph[1];
      dll_ff <= i_dll_on;
      o_rd_valid <= opp && rpipe_ff[rfirst + 3'h3];
      if (cmd_slot)
      begin
        rslot_ff <= !rslot_ff;
        rd_n_ff  <= !rissue;
        wr_n_ff  <= !wload;
        if (pop)
          addr_ff <= f_addr;
      end
      if (opp)
      begin
        d_ff     <= wsd_ff[0];
        bw_ff    <= wsm_ff[0];
        rpipe_ff <= {rpipe_ff[bsp_pkg::RD_PIPE_W-2:0], rissue};
        for (int i = 0; i < NS; i++)
        begin
          wsd_ff[i] <= nxt_wsd[i];
          wsm_ff[i] <= nxt_wsm[i];
        end
      end
    end
  end

  // q is sampled a quarter k period after each edge that launched it
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      o_rd_data <= '0;
    else if (opp)
    begin
      for (int j = 0; j < NB-1; j++)
        if (rpipe_ff[rfirst + 3'(j)])
          rbuf_ff[j] <= link.rd_data;
      if (rpipe_ff[rfirst + 3'h3])
        o_rd_data <= {link.rd_data, rbuf_ff[2], rbuf_ff[1], rbuf_ff[0]};
    end
  end

  assign link.k_clk            = k_ff;
  assign link.k_clk_n          = kn_ff;
  assign link.rd_sel_n         = rd_n_ff;
  assign link.wr_sel_n         = wr_n_ff;
  assign link.address_lines    = addr_ff;
  assign link.wr_data          = d_ff;
  assign link.byte_lane_mask_n = bw_ff;
  assign link.dll_on           = dll_ff;
endmodule : bsp_host

// ==== bsp_link_monitor.sv ====
`timescale 1ns/10ps
module bsp_link_monitor (
  input wire logic i_resetn,
  input wire logic k_clk,
  input wire logic k_clk_n,
  input wire logic rd_sel_n,
  input wire logic wr_sel_n,
  input wire logic dll_on,
  input wire logic echo_strobe,
  input wire logic echo_strobe_inverted,
  input wire logic output_valid_flag
);
  default clocking cb @(posedge k_clk);
  endclocking
  default disable iff (!i_resetn);

  chk_clk_pair: assert property (k_clk_n)
    else $error("inverted link clock low at rising edge");
  chk_strobe_rise: assert property (!echo_strobe && echo_strobe_inverted)
    else $error("echo strobes wrong before link clock rise");
  chk_strobe_fall: assert property (@(posedge k_clk_n) echo_strobe && !echo_strobe_inverted)
    else $error("echo strobes wrong before inverted clock rise");
  chk_read_lat_two: assert property (!rd_sel_n && dll_on && $past(dll_on, 3) |->
    ##3 output_valid_flag ##1 output_valid_flag)
    else $error("read valid window not at latency two");
  chk_read_lat_one: assert property (!rd_sel_n && !dll_on && !$past(dll_on, 3) |->
    ##2 output_valid_flag[*2])
    else $error("read valid window not at latency one");
  chk_valid_cause: assert property (output_valid_flag |->
    !$past(rd_sel_n, 2) || !$past(rd_sel_n, 3) || !$past(rd_sel_n, 4))
    else $error("valid flag without a read");
  chk_slot_parity: assert property (!rd_sel_n |-> wr_sel_n && $past(wr_sel_n, 2))
    else $error("read and write share a slot parity");
  chk_rd_single: assert property (!rd_sel_n |=> rd_sel_n)
    else $error("read select held past one cycle");
  chk_wr_single: assert property (!wr_sel_n |=> wr_sel_n)
    else $error("write select held past one cycle");

  cov_interleave: cover property (!rd_sel_n ##1 !wr_sel_n);
  cov_read_dll_off: cover property (!rd_sel_n && !dll_on);
  cov_reads_chained: cover property (output_valid_flag[*4]);
endmodule : bsp_link_monitor

// ==== burst4_ddr_sram_port_tb.sv ====
`timescale 1ns/10ps
module burst4_ddr_sram_port_tb;
  localparam int DW    = bsp_pkg::DATA_W_WIDE;
  localparam int AW    = 6;
  localparam int BW    = 4 * DW;
  localparam int MW    = BW / bsp_pkg::LANE_W;
  localparam int WD_NS = 200000;
  logic          i_clk;
  logic          resetn;
  logic          mem_resetn;
  logic          dll_en;
  logic          cmd_valid;
  logic          cmd_ready;
  logic          cmd_wr;
  logic [AW-1:0] cmd_addr;
  logic [BW-1:0] cmd_data;
  logic [MW-1:0] cmd_mask_n;
  logic          rd_valid;
  logic [BW-1:0] rd_data;
  logic          dll_bypass;
  logic          full_seen;
  logic [31:0]   lfsr = 32'h36D2;
  logic [31:0]   v;
  logic [BW-1:0] ref_m [2**AW];
  logic [BW-1:0] exp_q [$];
  int            failures;
  int            checked;

  bsp_link_if #(.DATA_W(DW), .ADDR_W(AW)) bsp_link_if_i ();
  bsp_host #(.DATA_W(DW), .ADDR_W(AW)) bsp_host_i (
    .i_clk(i_clk), .i_resetn(resetn), .i_dll_on(dll_en), .i_cmd_valid(cmd_valid),
    .o_cmd_ready(cmd_ready), .i_cmd_wr(cmd_wr), .i_cmd_addr(cmd_addr),
    .i_cmd_data(cmd_data), .i_cmd_mask_n(cmd_mask_n), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data), .link(bsp_link_if_i)
  );
  bsp_mem #(.DATA_W(DW), .ADDR_W(AW)) bsp_mem_i (
    .link(bsp_link_if_i), .i_resetn(mem_resetn), .o_dll_bypass(dll_bypass)
  );
  bsp_link_monitor bsp_link_monitor_i (
    .i_resetn(mem_resetn), .k_clk(bsp_link_if_i.k_clk), .k_clk_n(bsp_link_if_i.k_clk_n),
    .rd_sel_n(bsp_link_if_i.rd_sel_n), .wr_sel_n(bsp_link_if_i.wr_sel_n),
    .dll_on(bsp_link_if_i.dll_on), .echo_strobe(bsp_link_if_i.echo_strobe),
    .echo_strobe_inverted(bsp_link_if_i.echo_strobe_inverted),
    .output_valid_flag(bsp_link_if_i.output_valid_flag)
  );

  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  function automatic logic [BW-1:0] rnd_beats();
    logic [159:0] r;
    r = {rnd(), rnd(), rnd(), rnd(), rnd()};
    return r[BW-1:0];
  endfunction : rnd_beats

  // lane l of beat b sits at bit (b*4+l)*9, mask bit b*4+l, low writes
  function automatic logic [BW-1:0] merge(input logic [BW-1:0] o, input logic [BW-1:0] n,
                                          input logic [MW-1:0] m);
    logic [BW-1:0] r;
    r = o;
    for (int l = 0; l < MW; l++)
      if (!m[l])
        r[l*9 +: 9] = n[l*9 +: 9];
    return r;
  endfunction : merge

  task automatic check(input string name, input logic [BW-1:0] seen, input logic [BW-1:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // commands queue in order, so the model is updated at push time
  task automatic push(input logic wr, input logic [AW-1:0] a, input logic [BW-1:0] d,
                      input logic [MW-1:0] m);
    @(negedge i_clk);
    while (cmd_ready !== 1'b1)
    begin
      cmd_valid = 1'b0;
      full_seen = 1'b1;
      @(negedge i_clk);
    end
    cmd_valid  = 1'b1;
    cmd_wr     = wr;
    cmd_addr   = a;
    cmd_data   = d;
    cmd_mask_n = m;
    if (wr)
      ref_m[a] = merge(ref_m[a], d, m);
    else
      exp_q.push_back(ref_m[a]);
  endtask : push

  task automatic drain(input string name);
    int n;
    n = 0;
    @(negedge i_clk);
    cmd_valid = 1'b0;
    while (exp_q.size() != 0 && n < 4000)
    begin
      n++;
      @(negedge i_clk);
    end
    check("pending_reads", BW'(exp_q.size()), '0);
    // queued writes have no answer: give them time to land
    repeat (160) @(negedge i_clk);
    $display("test %s done", name);
  endtask : drain

  always @(negedge i_clk)
    if (rd_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("rd_count", BW'(1), BW'(0));
      else
        check("rd_data", rd_data, exp_q.pop_front());
    end

  initial
  begin
    #(WD_NS);
    failures++;
    $display("mismatch watchdog expected done seen timeout");
    summarize();
  end

  initial
  begin
    resetn     = 1'b0;
    mem_resetn = 1'b0;
    dll_en     = 1'b1;
    cmd_valid  = 1'b0;
    cmd_wr     = 1'b0;
    cmd_addr   = '0;
    cmd_data   = '0;
    cmd_mask_n = '1;
    full_seen  = 1'b0;
    failures   = 0;
    checked    = 0;
    repeat (20) @(negedge i_clk);
    resetn = 1'b1;
    // device resets only on link clock edges, which stand still in host reset
    repeat (24) @(negedge i_clk);
    mem_resetn = 1'b1;
    check("sel_idle", BW'({bsp_link_if_i.rd_sel_n, bsp_link_if_i.wr_sel_n}), BW'(2'h3));
    for (int a = 0; a < 2**AW; a++)
      push(1'b1, AW'(a), rnd_beats(), '0);
    drain("fill");
    check("dll_bypass_on", BW'(dll_bypass), BW'(1'b0));
    push(1'b1, 6'h3F, rnd_beats(), 16'hA5C3);
    push(1'b0, 6'h3F, '0, '1);
    push(1'b0, 6'h3F, '0, '1);
    push(1'b1, 6'h00, rnd_beats(), 16'hFFFF);
    push(1'b0, 6'h00, '0, '1);
    // read then write of one address: the read keeps the older bytes
    push(1'b0, 6'h21, '0, '1);
    push(1'b1, 6'h21, rnd_beats(), '0);
    push(1'b0, 6'h21, '0, '1);
    drain("coherency");
    repeat (300)
    begin
      v = rnd();
      push(v[31], v[AW-1:0], rnd_beats(), v[MW+7:8]);
    end
    drain("random");
    full_seen = 1'b0;
    repeat (24)
    begin
      v = rnd();
      push(1'b1, v[AW-1:0], rnd_beats(), v[MW-1:0]);
    end
    push(1'b0, v[AW-1:0], '0, '1);
    check("fifo_full", BW'(full_seen), BW'(1'b1));
    drain("fifo_full");
    // latency may change only with no read in flight
    @(negedge i_clk);
    dll_en = 1'b0;
    repeat (32) @(negedge i_clk);
    repeat (40)
    begin
      v = rnd();
      push(1'b0, v[AW-1:0], '0, '1);
    end
    check("dll_bypass", BW'(dll_bypass), BW'(1'b1));
    drain("dll_off");
    summarize();
  end
endmodule : burst4_ddr_sram_port_tb
